// file: hw/pms_regs.sv
// phy management status and control register bank with apb slave
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/100ps
module pms_regs #(
  parameter int ADDR_W = 8
) (
  input  wire logic              clk_sys,
  input  wire logic              reset_n,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  input  wire logic              softReset,
  input  wire logic              anRestartBit,
  input  wire logic              powerUpEvt,
  input  wire logic              anEnable,
  input  wire logic              anComplete,
  input  wire logic              msFaultEvt,
  input  wire logic              resolvedMaster,
  input  wire logic              localRxOk,
  input  wire logic              remoteRxOk,
  input  wire logic              lpGigFull,
  input  wire logic              lpGigHalf,
  input  wire logic              idleErrEvt,
  input  wire logic              linkUp,
  input  wire logic              pageRxNow,
  input  wire logic [1:0]        speedNow,
  input  wire logic              duplexFull,
  input  wire logic              txActive,
  input  wire logic              rxActive,
  input  wire logic [15:0]       mmdRdData,
  output logic                   roleManual,
  output logic                   roleManualMaster,
  output logic                   rolePreferMaster,
  output logic                   advGigFull,
  output logic                   advGigHalf,
  output logic [1:0]             crossoverSelect,
  output logic                   carrierSense,
  output logic                   sqeTestEn,
  output logic                   polForceNormal,
  output logic                   jabberEn,
  output logic [4:0]             mmdDevAddr,
  output logic [15:0]            mmdRegAddr,
  output logic                   mmdRdStb,
  output logic                   mmdWrStb,
  output logic [15:0]            mmdWrData
);
  import pms_pkg::*;

  if (ADDR_W < 8) begin : g_chk
    $error("pms_regs: ADDR_W must be at least 8");
  end

  logic [4:0]       gigCtrl_r;
  logic [4:0]       gigApplied_r;
  logic             msFault_r;
  logic [7:0]       idleCnt_r;
  logic [1:0]       mmdFn_r;
  logic [4:0]       mmdDev_r;
  logic [15:0]      mmdAddr_r;
  logic [1:0]       xover_r;
  logic [1:0]       xoverApplied_r;
  logic [3:0]       fnBits_r;
  logic             restartPrev_r;
  logic             completePrev_r;
  logic             linkPrev_r;
  logic             mmdRd_r;
  logic             mmdWr_r;
  logic [15:0]      mmdWd_r;
  logic [31:0]      rdData_r;
  logic             slvErr_r;
  logic [5:0]       idx;
  logic             mapped;
  logic             setupRd;
  logic             accessWr;
  logic             applyEvt;
  logic             resolved;
  logic             halfTen;
  logic [15:0]      rdMux;
  logic             incRd;
  logic             incWr;
  logic             upperZero;

  // upper address bits only exist on wider buses; a reversed slice would not elaborate
  if (ADDR_W > 8) begin : g_upper
    assign upperZero = paddr[ADDR_W-1:8] == '0;
  end else begin : g_noupper
    assign upperZero = 1'b1;
  end

  // index from word address; upper address bits must be zero
  assign idx      = paddr[7:2];
  assign mapped   = upperZero
                    && (idx == IDX_GIG_CTRL || idx == IDX_MS_STAT
                    || idx == IDX_MMD_CTRL || idx == IDX_MMD_DATA
                    || idx == IDX_EXT_STAT || idx == IDX_FUNC_CTRL
                    || idx == IDX_LINK_STAT);
  // reads sample and apply side effects in the setup cycle so the data
  // and the clear-on-read stay on the same edge
  assign setupRd  = psel && !penable && !pwrite && mapped;
  assign accessWr = psel && penable && pwrite && mapped;
  assign pready   = psel && penable;
  assign prdata   = rdData_r;
  assign pslverr  = slvErr_r && psel && penable;

  // trigger set for applying stored gigabit settings
  assign applyEvt = softReset || (anRestartBit && !restartPrev_r)
                    || powerUpEvt || (linkPrev_r && !linkUp);

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      restartPrev_r  <= 1'b0;
      completePrev_r <= 1'b0;
      linkPrev_r     <= 1'b0;
    end else begin
      restartPrev_r  <= anRestartBit;
      completePrev_r <= anComplete;
      linkPrev_r     <= linkUp;
    end
  end

  // gigabit role/advertisement control
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      gigCtrl_r    <= GC_RESET;
      gigApplied_r <= GC_RESET;
    end else begin
      if (accessWr && idx == IDX_GIG_CTRL) begin
        gigCtrl_r <= pwdata[GC_MANUAL:GC_ADVHALF];
      end
      if (applyEvt) begin
        gigApplied_r <= (accessWr && idx == IDX_GIG_CTRL)
                        ? pwdata[GC_MANUAL:GC_ADVHALF] : gigCtrl_r;
      end
    end
  end

  assign roleManual       = gigApplied_r[GC_MANUAL-GC_ADVHALF];
  assign roleManualMaster = roleManual && gigApplied_r[GC_MASTER-GC_ADVHALF];
  // preference only matters in automatic resolution
  assign rolePreferMaster = !roleManual
                            && gigApplied_r[GC_PORTPRF-GC_ADVHALF];
  assign advGigFull       = gigApplied_r[GC_ADVFULL-GC_ADVHALF];
  assign advGigHalf       = gigApplied_r[GC_ADVHALF-GC_ADVHALF];

  // role fault flag: a new fault beats any clear in the same cycle
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      msFault_r <= 1'b0;
    end else if (msFaultEvt) begin
      msFault_r <= 1'b1;
    end else if ((setupRd && idx == IDX_MS_STAT)
                 || (anRestartBit && !restartPrev_r)
                 || (anComplete && !completePrev_r)) begin
      msFault_r <= 1'b0;
    end
  end

  // idle error counter; an error on the read edge starts the new count
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      idleCnt_r <= 8'h00;
    end else if (setupRd && idx == IDX_MS_STAT) begin
      idleCnt_r <= {7'h00, idleErrEvt};
    end else if (idleErrEvt && idleCnt_r != IDLE_MAX) begin
      idleCnt_r <= idleCnt_r + 8'h01;
    end
  end

  // mmd control
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      mmdFn_r  <= 2'h0;
      mmdDev_r <= 5'h00;
    end else if (accessWr && idx == IDX_MMD_CTRL) begin
      mmdFn_r  <= pwdata[MMD_FN_HI:MMD_FN_LO];
      mmdDev_r <= pwdata[MMD_DEV_W-1:0];
    end
  end

  assign incRd = pms_mmd_fn_t'(mmdFn_r) == MMD_DATA_INC_RW;
  assign incWr = pms_mmd_fn_t'(mmdFn_r) == MMD_DATA_INC_RW
                 || pms_mmd_fn_t'(mmdFn_r) == MMD_DATA_INC_WR;

  // mmd address register and data port strobes
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      mmdAddr_r <= 16'h0000;
      mmdRd_r   <= 1'b0;
      mmdWr_r   <= 1'b0;
      mmdWd_r   <= 16'h0000;
    end else begin
      mmdRd_r <= 1'b0;
      mmdWr_r <= 1'b0;
      if (accessWr && idx == IDX_MMD_DATA) begin
        if (pms_mmd_fn_t'(mmdFn_r) == MMD_ADDR) begin
          mmdAddr_r <= pwdata[15:0];
        end else begin
          mmdWr_r <= 1'b1;
          mmdWd_r <= pwdata[15:0];
          if (incWr) begin
            mmdAddr_r <= mmdAddr_r + 16'h0001;
          end
        end
      end else if (setupRd && idx == IDX_MMD_DATA
                   && pms_mmd_fn_t'(mmdFn_r) != MMD_ADDR) begin
        mmdRd_r <= 1'b1;
        if (incRd) begin
          mmdAddr_r <= mmdAddr_r + 16'h0001;
        end
      end
    end
  end

  // strobes carry the address used before any post-increment
  logic [15:0] mmdAddrUsed_r;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      mmdAddrUsed_r <= 16'h0000;
    end else if ((accessWr || setupRd) && idx == IDX_MMD_DATA) begin
      mmdAddrUsed_r <= mmdAddr_r;
    end
  end

  assign mmdDevAddr = mmdDev_r;
  assign mmdRegAddr = mmdAddrUsed_r;
  assign mmdRdStb   = mmdRd_r;
  assign mmdWrStb   = mmdWr_r;
  assign mmdWrData  = mmdWd_r;

  // function control
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      xover_r        <= XOVER_RESET;
      xoverApplied_r <= XOVER_RESET;
      fnBits_r       <= 4'h2;
    end else begin
      if (accessWr && idx == IDX_FUNC_CTRL) begin
        xover_r  <= pwdata[FC_XOVER_HI:FC_XOVER_LO];
        fnBits_r <= pwdata[FC_CRSTX:FC_DISJAB];
      end
      // crossover change waits for the software reset
      if (softReset) begin
        xoverApplied_r <= xover_r;
      end
    end
  end

  // reserved code is applied like any other mode
  assign crossoverSelect = xoverApplied_r;
  assign resolved   = anEnable ? anComplete : 1'b1;
  assign halfTen    = speedNow == SPD_10 && !duplexFull;
  assign carrierSense = rxActive
                        || (txActive && fnBits_r[FC_CRSTX]
                            && (halfTen || speedNow == SPD_100));
  assign sqeTestEn  = fnBits_r[FC_SQE] && !duplexFull;
  assign polForceNormal = !fnBits_r[FC_POLINV] && speedNow == SPD_10;
  assign jabberEn   = !fnBits_r[FC_DISJAB] && halfTen;

  // read mux; unlisted bits are zero
  always_comb begin
    rdMux = 16'h0000;
    unique case (idx)
      IDX_GIG_CTRL: begin
        rdMux[GC_MANUAL:GC_ADVHALF] = gigCtrl_r;
      end
      IDX_MS_STAT: begin
        rdMux[MS_FAULT]  = msFault_r;
        rdMux[MS_RESOLV] = resolvedMaster;
        rdMux[MS_LOCOK]  = localRxOk;
        rdMux[MS_REMOK]  = remoteRxOk;
        rdMux[MS_LPFULL] = lpGigFull;
        rdMux[MS_LPHALF] = lpGigHalf;
        rdMux[7:0]       = idleCnt_r;
      end
      IDX_MMD_CTRL: begin
        rdMux[MMD_FN_HI:MMD_FN_LO] = mmdFn_r;
        rdMux[MMD_DEV_W-1:0]       = mmdDev_r;
      end
      IDX_MMD_DATA: begin
        rdMux = (pms_mmd_fn_t'(mmdFn_r) == MMD_ADDR)
                ? mmdAddr_r : mmdRdData;
      end
      IDX_EXT_STAT: begin
        rdMux = EXT_STAT_VAL;
      end
      IDX_FUNC_CTRL: begin
        rdMux[FC_XOVER_HI:FC_XOVER_LO] = xover_r;
        rdMux[FC_CRSTX:FC_DISJAB]      = fnBits_r;
      end
      IDX_LINK_STAT: begin
        rdMux[LS_SPD_HI:LS_SPD_LO] = resolved ? speedNow : SPD_10;
        rdMux[LS_DUPLEX] = resolved && duplexFull;
        rdMux[LS_PAGE]   = pageRxNow;
        rdMux[LS_RESOLV] = resolved;
        rdMux[LS_LINK]   = linkUp;
      end
      default: begin
        rdMux = 16'h0000;
      end
    endcase
  end

  // read data and error latched in the setup cycle
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rdData_r <= 32'h0000_0000;
      slvErr_r <= 1'b0;
    end else if (psel && !penable) begin
      rdData_r <= (mapped && !pwrite) ? {16'h0000, rdMux} : 32'h0000_0000;
      slvErr_r <= !mapped;
    end
  end
endmodule

// file: shared/pms_pkg.sv
// constants for the phy management status and control register bank
package pms_pkg;
  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_GIG_CTRL  = 6'h09;
  localparam logic [5:0] IDX_MS_STAT   = 6'h0A;
  localparam logic [5:0] IDX_MMD_CTRL  = 6'h0D;
  localparam logic [5:0] IDX_MMD_DATA  = 6'h0E;
  localparam logic [5:0] IDX_EXT_STAT  = 6'h0F;
  localparam logic [5:0] IDX_FUNC_CTRL = 6'h10;
  localparam logic [5:0] IDX_LINK_STAT = 6'h11;
  // gigabit control tail fields
  localparam int GC_MANUAL  = 12;
  localparam int GC_MASTER  = 11;
  localparam int GC_PORTPRF = 10;
  localparam int GC_ADVFULL = 9;
  localparam int GC_ADVHALF = 8;
  localparam logic [4:0] GC_RESET = 5'h02;
  // master/slave status fields
  localparam int MS_FAULT   = 15;
  localparam int MS_RESOLV  = 14;
  localparam int MS_LOCOK   = 13;
  localparam int MS_REMOK   = 12;
  localparam int MS_LPFULL  = 11;
  localparam int MS_LPHALF  = 10;
  localparam logic [7:0] IDLE_MAX = 8'hFF;
  // mmd access
  localparam int MMD_FN_HI  = 15;
  localparam int MMD_FN_LO  = 14;
  localparam int MMD_DEV_W  = 5;
  typedef enum logic [1:0] {
    MMD_ADDR, MMD_DATA_NOINC, MMD_DATA_INC_RW, MMD_DATA_INC_WR
  } pms_mmd_fn_t;
  // extended status: only 1000BASE-T full duplex
  localparam logic [15:0] EXT_STAT_VAL = 16'h2000;
  // function control fields
  localparam int FC_XOVER_HI = 6;
  localparam int FC_XOVER_LO = 5;
  localparam int FC_CRSTX    = 3;
  localparam int FC_SQE      = 2;
  localparam int FC_POLINV   = 1;
  localparam int FC_DISJAB   = 0;
  localparam logic [1:0] XOVER_RESET = 2'h3;
  localparam logic [1:0] XOVER_RSVD  = 2'h2;
  // link status fields
  localparam int LS_SPD_HI = 15;
  localparam int LS_SPD_LO = 14;
  localparam int LS_DUPLEX = 13;
  localparam int LS_PAGE   = 12;
  localparam int LS_RESOLV = 11;
  localparam int LS_LINK   = 10;
  localparam logic [1:0] SPD_1000 = 2'h2;
  localparam logic [1:0] SPD_100  = 2'h1;
  localparam logic [1:0] SPD_10   = 2'h0;
endpackage

// file: testbench/pms_mmd_model.sv
// behavioural mmd register space behind the indirect port
`timescale 1ns/100ps
module pms_mmd_model (
  input  wire logic        clk_sys,
  input  wire logic [4:0]  mmdDevAddr,
  input  wire logic [15:0] mmdRegAddr,
  input  wire logic        mmdWrStb,
  input  wire logic [15:0] mmdWrData,
  output logic      [15:0] mmdRdData
);
  logic [15:0] mem [256];
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 16'hA5A5 ^ 16'(i);
    end
  end
  // limitation: only the last strobed address is seen
  assign mmdRdData = mem[{mmdDevAddr[3:0], mmdRegAddr[3:0]}];
  always @(posedge clk_sys) begin
    if (mmdWrStb === 1'b1) begin
      mem[{mmdDevAddr[3:0], mmdRegAddr[3:0]}] <= mmdWrData;
    end
  end
endmodule

// file: testbench/pms_regs_assertions.sv
// concurrent checks on the register bank ports
`timescale 1ns/100ps
module pms_regs_chk #(
  parameter int ADDR_W = 8
) (
  input wire logic              clk_sys,
  input wire logic              reset_n,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       prdata,
  input wire logic              pslverr,
  input wire logic              softReset,
  input wire logic              anEnable,
  input wire logic              anComplete,
  input wire logic              linkUp,
  input wire logic [1:0]        speedNow,
  input wire logic              duplexFull,
  input wire logic              roleManual,
  input wire logic              rolePreferMaster,
  input wire logic [1:0]        crossoverSelect,
  input wire logic              sqeTestEn,
  input wire logic              polForceNormal,
  input wire logic              jabberEn,
  input wire logic              mmdWrStb
);
  import pms_pkg::*;
  logic mapped;
  logic dataWr;
  assign mapped = paddr[ADDR_W-1:2] inside {IDX_GIG_CTRL, IDX_MS_STAT, IDX_MMD_CTRL,
                                            IDX_MMD_DATA, IDX_EXT_STAT, IDX_FUNC_CTRL, IDX_LINK_STAT};
  assign dataWr = psel && penable && pwrite && paddr == {IDX_MMD_DATA, 2'b00};
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  sequence rdSetup(logic [5:0] idx);
    psel && !penable && !pwrite && paddr == {idx, 2'b00};
  endsequence
  AST_EXT_FIXED: assert property (
    rdSetup(IDX_EXT_STAT) ##1 (psel && penable) |-> prdata == {16'h0000, EXT_STAT_VAL})
    else $error("extended status read wrong");
  AST_LINK_RD: assert property (
    rdSetup(IDX_LINK_STAT) |=> prdata[LS_LINK] == $past(linkUp)
      && prdata[LS_RESOLV] == ($past(anEnable) ? $past(anComplete) : 1'b1))
    else $error("link status read wrong");
  AST_UNMAPPED: assert property (
    psel && penable && !mapped |-> pslverr && prdata == 32'h00000000)
    else $error("unmapped access not refused");
  AST_XOVER_APPLY: assert property (
    $changed(crossoverSelect) |-> $past(softReset))
    else $error("crossover changed without software reset");
  AST_PREF_GATE: assert property (
    roleManual |-> !rolePreferMaster)
    else $error("port preference used in manual mode");
  AST_SQE_FULL: assert property (
    duplexFull |-> !sqeTestEn)
    else $error("sqe test on in full duplex");
  AST_POL_10: assert property (
    polForceNormal |-> speedNow == SPD_10)
    else $error("polarity forced outside 10 mode");
  AST_JAB_10HALF: assert property (
    jabberEn |-> speedNow == SPD_10 && !duplexFull)
    else $error("jabber active outside 10 half");
  AST_MMD_WR: assert property (
    mmdWrStb |-> $past(dataWr))
    else $error("mmd write strobe without data write");
endmodule
bind pms_regs pms_regs_chk #(.ADDR_W(ADDR_W)) i_pms_regs_chk (
  .clk_sys, .reset_n, .psel, .penable, .pwrite, .paddr, .prdata, .pslverr, .softReset,
  .anEnable, .anComplete, .linkUp, .speedNow, .duplexFull, .roleManual, .rolePreferMaster,
  .crossoverSelect, .sqeTestEn, .polForceNormal, .jabberEn, .mmdWrStb);

// file: testbench/test_pms_regs.sv
// self-checking bench for the register bank
`timescale 1ns/100ps
module test_pms_regs;
  import pms_pkg::*;
  logic        clk_sys, reset_n, psel, penable, pwrite, pready, pslverr, slvErr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdq;
  logic        softReset, anRestartBit, powerUpEvt, anEnable, anComplete, msFaultEvt;
  logic        resolvedMaster, localRxOk, remoteRxOk, lpGigFull, lpGigHalf, idleErrEvt;
  logic        linkUp, pageRxNow, duplexFull, txActive, rxActive, mmdRdStb, mmdWrStb;
  logic        roleManual, roleManualMaster, rolePreferMaster, advGigFull, advGigHalf;
  logic        carrierSense, sqeTestEn, polForceNormal, jabberEn;
  logic [1:0]  speedNow, crossoverSelect;
  logic [4:0]  mmdDevAddr;
  logic [15:0] mmdRdData, mmdRegAddr, mmdWrData, stAddr, stData;
  int          errors, checked, stCnt;
  pms_regs #(.ADDR_W(8)) i_pms_regs (
    .clk_sys, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
    .pslverr, .softReset, .anRestartBit, .powerUpEvt, .anEnable, .anComplete, .msFaultEvt,
    .resolvedMaster, .localRxOk, .remoteRxOk, .lpGigFull, .lpGigHalf, .idleErrEvt, .linkUp,
    .pageRxNow, .speedNow, .duplexFull, .txActive, .rxActive, .mmdRdData, .roleManual,
    .roleManualMaster, .rolePreferMaster, .advGigFull, .advGigHalf, .crossoverSelect,
    .carrierSense, .sqeTestEn, .polForceNormal, .jabberEn, .mmdDevAddr, .mmdRegAddr,
    .mmdRdStb, .mmdWrStb, .mmdWrData);
  pms_mmd_model i_pms_mmd_model (
    .clk_sys, .mmdDevAddr, .mmdRegAddr, .mmdWrStb, .mmdWrData, .mmdRdData);
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // mid-cycle sampling keeps strobe capture off the clock edge
  always @(negedge clk_sys) begin
    if (mmdWrStb === 1'b1 || mmdRdStb === 1'b1) begin
      stCnt++;
      stAddr = mmdRegAddr;
      stData = mmdWrData;
    end
  end
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", nm, e, g);
      errors++;
    end
  endtask
  task automatic apb(input logic w, input logic [5:0] idx, input logic [15:0] d);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {16'h0000, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rdq = prdata;
    slvErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      errors++;
      tally_and_finish();
    end
  endtask
  task automatic rdc(input logic [5:0] idx, input logic [15:0] e);
    apb(1'b0, idx, 16'h0000);
    chk($sformatf("read of index %h", idx), {16'h0000, e}, rdq);
  endtask
  task automatic mop(input logic w, input logic [15:0] d, input logic [15:0] ea, input logic ck);
    int c;
    c = stCnt;
    apb(w, IDX_MMD_DATA, d);
    cyc(1);
    chk("mmd strobe count", c + 1, stCnt);
    chk("mmdRegAddr", ea, stAddr);
    if (w || ck) begin
      chk("mmd data", d, w ? stData : rdq[15:0]);
    end
  endtask
  function automatic logic [4:0] ap(input logic [15:0] v);
    return {v[12], v[12] & v[11], v[10] & ~v[12], v[9], v[8]};
  endfunction
  task automatic tReset();
    rdc(IDX_GIG_CTRL, 16'h0200);
    rdc(IDX_FUNC_CTRL, 16'h0062);
    rdc(IDX_EXT_STAT, 16'h2000);
    rdc(6'h20, 16'h0000);
    chk("pslverr", 32'h1, slvErr);
    $display("reset values test done");
  endtask
  task automatic tGig();
    logic [15:0] v [4] = '{16'h1F00, 16'h0400, 16'h0200, 16'h1100};
    logic [15:0] p;
    p = 16'h0200;
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, IDX_GIG_CTRL, v[k]);
      rdc(IDX_GIG_CTRL, v[k]);
      chk("held role", ap(p), {roleManual, roleManualMaster, rolePreferMaster, advGigFull,
                               advGigHalf});
      case (k)
        0: softReset <= 1'b1;
        1: anRestartBit <= 1'b1;
        2: powerUpEvt <= 1'b1;
        default: linkUp <= 1'b0;
      endcase
      cyc(1);
      softReset <= 1'b0;
      powerUpEvt <= 1'b0;
      cyc(2);
      chk("applied role", ap(v[k]), {roleManual, roleManualMaster, rolePreferMaster,
                                     advGigFull, advGigHalf});
      anRestartBit <= 1'b0;
      linkUp <= 1'b1;
      p = v[k];
    end
    $display("gigabit control test done");
  endtask
  task automatic tMs();
    resolvedMaster <= 1'b1;
    localRxOk <= 1'b1;
    lpGigFull <= 1'b1;
    msFaultEvt <= 1'b1;
    cyc(1);
    msFaultEvt <= 1'b0;
    rdc(IDX_MS_STAT, 16'hE800);
    rdc(IDX_MS_STAT, 16'h6800);
    for (int k = 0; k < 2; k++) begin
      msFaultEvt <= 1'b1;
      cyc(1);
      msFaultEvt <= 1'b0;
      anRestartBit <= (k == 0);
      anComplete <= (k == 1);
      cyc(2);
      rdc(IDX_MS_STAT, 16'h6800);
      anRestartBit <= 1'b0;
      anComplete <= 1'b0;
    end
    {resolvedMaster, localRxOk, remoteRxOk, lpGigFull, lpGigHalf} <= 5'b10101;
    idleErrEvt <= 1'b1;
    cyc(3);
    idleErrEvt <= 1'b0;
    rdc(IDX_MS_STAT, 16'h5403);
    rdc(IDX_MS_STAT, 16'h5400);
    idleErrEvt <= 1'b1;
    cyc(300);
    idleErrEvt <= 1'b0;
    rdc(IDX_MS_STAT, 16'h54FF);
    $display("role status test done");
  endtask
  task automatic tMmd();
    apb(1'b1, IDX_MMD_CTRL, 16'h0007);
    apb(1'b1, IDX_MMD_DATA, 16'h0012);
    rdc(IDX_MMD_DATA, 16'h0012);
    chk("mmd strobe count", 0, stCnt);
    chk("mmdDevAddr", 7, mmdDevAddr);
    apb(1'b1, IDX_MMD_CTRL, 16'h4007);
    mop(1'b1, 16'hBEEF, 16'h0012, 1'b0);
    mop(1'b0, 16'hBEEF, 16'h0012, 1'b1);
    apb(1'b1, IDX_MMD_CTRL, 16'h8007);
    mop(1'b1, 16'h1111, 16'h0012, 1'b0);
    mop(1'b1, 16'h2222, 16'h0013, 1'b0);
    mop(1'b0, 16'h0000, 16'h0014, 1'b0);
    apb(1'b1, IDX_MMD_CTRL, 16'hC007);
    mop(1'b0, 16'h0000, 16'h0015, 1'b0);
    mop(1'b0, 16'h0000, 16'h0015, 1'b0);
    mop(1'b1, 16'h3333, 16'h0015, 1'b0);
    mop(1'b1, 16'h4444, 16'h0016, 1'b0);
    apb(1'b1, IDX_MMD_CTRL, 16'hFFE3);
    rdc(IDX_MMD_CTRL, 16'hC003);
    $display("mmd access test done");
  endtask
  task automatic tFunc();
    apb(1'b1, IDX_FUNC_CTRL, 16'hFFFF);
    rdc(IDX_FUNC_CTRL, 16'h006F);
    speedNow <= SPD_10;
    txActive <= 1'b1;
    apb(1'b1, IDX_FUNC_CTRL, 16'h000C);
    cyc(1);
    chk("held crossover", 3, crossoverSelect);
    chk("function outs", 4'hF, {carrierSense, sqeTestEn, polForceNormal,
                                jabberEn});
    for (int k = 0; k < 2; k++) begin
      softReset <= 1'b1;
      cyc(1);
      softReset <= 1'b0;
      cyc(2);
      chk("crossover", k, crossoverSelect);
      apb(1'b1, IDX_FUNC_CTRL, 16'h0023);
      cyc(1);
      chk("function outs", 4'h0, {carrierSense, sqeTestEn, polForceNormal,
                                  jabberEn});
    end
    duplexFull <= 1'b1;
    apb(1'b1, IDX_FUNC_CTRL, 16'h0024);
    cyc(1);
    chk("sqeTestEn", 0, sqeTestEn);
    txActive <= 1'b0;
    rxActive <= 1'b1;
    cyc(1);
    chk("carrierSense", 1, carrierSense);
    rxActive <= 1'b0;
    $display("function control test done");
  endtask
  task automatic tLink();
    logic [1:0] s [3] = '{SPD_1000, SPD_100, SPD_10};
    logic b;
    for (int k = 0; k < 3; k++) begin
      b = k[0];
      {speedNow, duplexFull, linkUp, pageRxNow, anEnable, anComplete} <= {s[k], b, ~b, b, 2'b10};
      rdc(IDX_LINK_STAT, {3'b000, b, 1'b0, ~b, 10'h000});
      anComplete <= 1'b1;
      rdc(IDX_LINK_STAT, {s[k], b, b, 1'b1, ~b, 10'h000});
      anEnable <= 1'b0;
      anComplete <= 1'b0;
      rdc(IDX_LINK_STAT, {s[k], b, b, 1'b1, ~b, 10'h000});
    end
    $display("link status test done");
  endtask
  initial begin
    {reset_n, psel, penable, pwrite, paddr, pwdata} = '0;
    {softReset, anRestartBit, powerUpEvt, anComplete, msFaultEvt, resolvedMaster} = '0;
    {localRxOk, remoteRxOk, lpGigFull, lpGigHalf, idleErrEvt, pageRxNow} = '0;
    {speedNow, duplexFull, txActive, rxActive} = '0;
    linkUp = 1'b1;
    anEnable = 1'b1;
    cyc(16);
    reset_n <= 1'b1;
    tReset();
    tGig();
    tMs();
    tMmd();
    tFunc();
    tLink();
    tally_and_finish();
  end
endmodule
